// [design/logic_cell.sv]
/*
 * one logic cell: lookup table, one-bit add/subtract, register.
 * assumes gated clock ticks from the cluster.
 */
`timescale 1ns/10ps

module logic_cell
(
    input wire logic core_clk,
    input wire logic rst,
    input wire cluster_pkg::cell_cfg_t cfg,
    input wire logic [3:0] dataIn,
    input wire cluster_pkg::ctrl_t ctl,
    input wire logic tick1,
    input wire logic tick2,
    input wire logic lutChainIn,
    input wire logic regChainIn,
    input wire logic carryIn,
    output logic regOut,
    output logic lutOut,
    output logic carryOut
);

    // =====
    // combinational part
    logic opA;
    logic opB;
    logic sum;
    logic [3:0] lutIn;
    logic clear;
    logic preset;
    logic tick;

    assign opA = cfg.lutChain ? lutChainIn : dataIn[0];
    assign lutIn = {dataIn[3:1], opA};
    assign opB = dataIn[1] ^ ctl.addSub;
    assign sum = opA ^ opB ^ carryIn;
    assign carryOut = cfg.arith & ((opA & opB) | (opA & carryIn) | (opB & carryIn));
    assign lutOut = cfg.arith ? sum : cfg.lutMask[lutIn];

    assign clear = ((cfg.clrSel == cluster_pkg::CLR_ONE) & ctl.aclr1)
                 | ((cfg.clrSel == cluster_pkg::CLR_TWO) & ctl.aclr2)
                 | ((cfg.clrSel == cluster_pkg::CLR_BOTH) & (ctl.aclr1 | ctl.aclr2));
    assign preset = cfg.presetUse & ctl.apre;
    // clock two serves the falling-edge registers of the cluster
    assign tick = cfg.clkSel ? tick2 : tick1;

    // =====
    // register: clears and load act at once, the rest waits for a gated tick
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            regOut <= 1'b0;
        end
        else if (clear)
        begin
            regOut <= 1'b0;
        end
        else if (preset)
        begin
            regOut <= dataIn[3];
        end
        else if (tick)
        begin
            if (ctl.sclr)
            begin
                regOut <= 1'b0;
            end
            else if (ctl.sload)
            begin
                regOut <= dataIn[3];
            end
            else
            begin
                case (cfg.dSel)
                    cluster_pkg::DSEL_LUT: regOut <= lutOut;
                    cluster_pkg::DSEL_REG_CHAIN: regOut <= regChainIn;
                    cluster_pkg::DSEL_DATA2: regOut <= dataIn[2];
                    default: regOut <= lutOut;
                endcase
            end
        end
    end

endmodule // logic_cell

// [design/logic_cluster.sv]
/*
 * ten-cell logic cluster: control generation, chains, local lines.
 * configured over an Avalon-MM slave with waitrequest.
 * assumes async row clock pins; routing inputs share core_clk.
 */
// Design decisions made here: the register offsets and the Avalon-MM register port.
// Notes on behaviour
// - ten cells share controls, chains and local lines
// - two clocks, two enables, two clears, sync clear, preset, sync load, add/subtract
// - at most ten control signals in use at once
// - each cluster clock pairs with its own enable
// - rising-edge cells use clock one, falling-edge cells clock two
// - an inactive enable stops its clock; no clocked register updates
// - two independent asynchronous clears and one asynchronous load or preset
// - with load data high, asynchronous load presets the register
// - add/subtract select makes each cell a one-bit adder or subtractor
// - controls come from the eight row clocks or local lines
// - a cell's lookup output feeds the next cell directly
// - a cell's register output feeds the next register directly
// - local lines come from routing, own cell outputs and direct links
// - sync clear or load acts on all registers at the next edge
// - subtraction inverts operand B and forces first carry-in to one
`timescale 1ns/10ps

module logic_cluster
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [7:0] rowClock,
    input wire logic [1:0] rowRoute,
    input wire logic [1:0] colRoute,
    input wire logic leftLink,
    input wire logic rightLink,
    input wire logic carryIn,
    input wire logic lutChainIn,
    input wire logic regChainIn,
    output logic [9:0] cellReg,
    output logic lutChainOut,
    output logic regChainOut,
    output logic carryOut,
    output logic [9:0] ctrlActive
);

    // =====
    // configuration storage
    logic [31:0] srcA;
    logic [7:0] srcB;
    logic [9:0] useMask;
    cluster_pkg::cell_cfg_t cellCfg [cluster_pkg::CELL_COUNT];
    logic [15:0] cellSel [cluster_pkg::CELL_COUNT];

    // =====
    // row clock synchroniser
    logic [7:0] rowSync1;
    logic [7:0] rowSync2;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rowSync1 <= 8'h00;
            rowSync2 <= 8'h00;
        end
        else
        begin
            rowSync1 <= rowClock;
            rowSync2 <= rowSync1;
        end
    end

    // =====
    // local interconnect and control line pool
    logic [15:0] localLine;
    logic [15:0] ctrlLine;
    logic [39:0] srcAll;
    logic [9:0] ctrlRaw;
    cluster_pkg::ctrl_t ctrl;

    assign localLine = {rowRoute, colRoute, leftLink, rightLink, cellReg};
    assign ctrlLine = {localLine[7:0], rowSync2};
    assign srcAll = {srcB, srcA};

    // an unused control sits inactive
    genvar k;
    generate
        for (k = 0; k < cluster_pkg::CTRL_COUNT; k++)
        begin : g_ctrl
            assign ctrlRaw[k] = useMask[k]
                              & ctrlLine[srcAll[k*cluster_pkg::SEL_W +: cluster_pkg::SEL_W]];
        end
    endgenerate

    always_comb
    begin
        ctrl.clk1 = ctrlRaw[cluster_pkg::CTL_CLK1];
        ctrl.clk2 = ctrlRaw[cluster_pkg::CTL_CLK2];
        ctrl.ena1 = ctrlRaw[cluster_pkg::CTL_ENA1];
        ctrl.ena2 = ctrlRaw[cluster_pkg::CTL_ENA2];
        ctrl.aclr1 = ctrlRaw[cluster_pkg::CTL_ACLR1];
        ctrl.aclr2 = ctrlRaw[cluster_pkg::CTL_ACLR2];
        ctrl.sclr = ctrlRaw[cluster_pkg::CTL_SCLR];
        ctrl.apre = ctrlRaw[cluster_pkg::CTL_APRE];
        ctrl.sload = ctrlRaw[cluster_pkg::CTL_SLOAD];
        ctrl.addSub = ctrlRaw[cluster_pkg::CTL_ADDSUB];
    end

    // =====
    // clock edges and enable gating
    logic clk1Prev;
    logic clk2Prev;
    logic ena1Gate;
    logic ena2Gate;
    logic tick1;
    logic tick2;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            clk1Prev <= 1'b0;
            clk2Prev <= 1'b0;
        end
        else
        begin
            clk1Prev <= ctrl.clk1;
            clk2Prev <= ctrl.clk2;
        end
    end

    // enable is only sampled in the inactive phase so a tick is never cut short
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ena1Gate <= 1'b0;
            ena2Gate <= 1'b0;
        end
        else
        begin
            if (!ctrl.clk1)
            begin
                ena1Gate <= ctrl.ena1;
            end
            if (ctrl.clk2)
            begin
                ena2Gate <= ctrl.ena2;
            end
        end
    end

    assign tick1 = ctrl.clk1 & ~clk1Prev & ena1Gate;
    assign tick2 = ~ctrl.clk2 & clk2Prev & ena2Gate;

    // =====
    // the ten cells and their chains
    logic [9:0] lutOut;
    logic [10:0] carry;
    logic [9:0] regNow;

    // first cell takes the forced carry when subtracting
    assign carry[0] = ctrl.addSub | carryIn;

    genvar i;
    generate
        for (i = 0; i < cluster_pkg::CELL_COUNT; i++)
        begin : g_cell
            logic [3:0] dataIn;
            logic lutPrev;
            logic regPrev;
            genvar j;
            for (j = 0; j < 4; j++)
            begin : g_data
                assign dataIn[j] = localLine[cellSel[i][j*4 +: 4]];
            end
            if (i == 0)
            begin : g_first
                assign lutPrev = lutChainIn;
                assign regPrev = regChainIn;
            end
            else
            begin : g_next
                assign lutPrev = lutOut[i-1];
                assign regPrev = regNow[i-1];
            end
            logic_cell u_cell
            (
                .core_clk(core_clk),
                .rst(rst),
                .cfg(cellCfg[i]),
                .dataIn(dataIn),
                .ctl(ctrl),
                .tick1(tick1),
                .tick2(tick2),
                .lutChainIn(lutPrev),
                .regChainIn(regPrev),
                .carryIn(carry[i]),
                .regOut(regNow[i]),
                .lutOut(lutOut[i]),
                .carryOut(carry[i+1])
            );
        end
    endgenerate

    assign cellReg = regNow;
    assign regChainOut = regNow[9];

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            lutChainOut <= 1'b0;
            carryOut <= 1'b0;
            ctrlActive <= 10'h000;
        end
        else
        begin
            lutChainOut <= lutOut[9];
            carryOut <= carry[10];
            ctrlActive <= ctrlRaw;
        end
    end

    // =====
    // register bus
    logic request;
    logic accept;
    logic cellHitCfg;
    logic cellHitSel;
    logic [7:0] cellOffCfg;
    logic [7:0] cellOffSel;
    logic [3:0] cellIdx;
    logic [31:0] readMux;

    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0] be);
        logic [31:0] result;
        result = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                result[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return result;
    endfunction

    assign request = read | write;
    // completes where waitrequest is seen low
    assign accept = request & ~waitrequest;
    assign cellOffCfg = address - cluster_pkg::OFF_CELL_CFG;
    assign cellOffSel = address - cluster_pkg::OFF_CELL_SEL;
    assign cellHitCfg = (address >= cluster_pkg::OFF_CELL_CFG) & (cellOffCfg[1:0] == 2'h0)
                      & (cellOffCfg[7:2] < 6'(cluster_pkg::CELL_COUNT));
    assign cellHitSel = (address >= cluster_pkg::OFF_CELL_SEL) & (cellOffSel[1:0] == 2'h0)
                      & (cellOffSel[7:2] < 6'(cluster_pkg::CELL_COUNT));
    assign cellIdx = cellHitCfg ? cellOffCfg[5:2] : cellOffSel[5:2];

    always_comb
    begin
        readMux = 32'h0000_0000;
        if (address == cluster_pkg::OFF_SRC_A)
        begin
            readMux = srcA;
        end
        else if (address == cluster_pkg::OFF_SRC_B)
        begin
            readMux = {24'h000000, srcB};
        end
        else if (address == cluster_pkg::OFF_USE)
        begin
            readMux = {22'h000000, useMask};
        end
        else if (address == cluster_pkg::OFF_STATUS)
        begin
            readMux = {6'h00, ctrlRaw, 6'h00, regNow};
        end
        else if (address == cluster_pkg::OFF_CHAIN)
        begin
            readMux = {29'h00000000, carry[10], lutOut[9], regNow[9]};
        end
        else if (cellHitCfg)
        begin
            readMux = cellCfg[cellIdx];
        end
        else if (cellHitSel)
        begin
            readMux = {16'h0000, cellSel[cellIdx]};
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
        end
        else
        begin
            if (request & waitrequest)
            begin
                waitrequest <= 1'b0;
                readdata <= readMux;
            end
            else
            begin
                waitrequest <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            srcA <= cluster_pkg::RST_SRC_A;
            srcB <= cluster_pkg::RST_SRC_B;
            useMask <= cluster_pkg::RST_USE;
        end
        else if (accept & write)
        begin
            if (address == cluster_pkg::OFF_SRC_A)
            begin
                srcA <= mergeBytes(srcA, writedata, byteenable);
            end
            if ((address == cluster_pkg::OFF_SRC_B) & byteenable[0])
            begin
                srcB <= writedata[7:0];
            end
            // only ten use bits exist, so no more than ten controls can be live
            if (address == cluster_pkg::OFF_USE)
            begin
                useMask[7:0] <= byteenable[0] ? writedata[7:0] : useMask[7:0];
                useMask[9:8] <= byteenable[1] ? writedata[9:8] : useMask[9:8];
            end
        end
    end

    generate
        for (i = 0; i < cluster_pkg::CELL_COUNT; i++)
        begin : g_cfg
            always_ff @(posedge core_clk)
            begin
                if (rst)
                begin
                    cellCfg[i] <= cluster_pkg::RST_CELL_CFG;
                    cellSel[i] <= cluster_pkg::RST_CELL_SEL;
                end
                else if (accept & write & (cellIdx == 4'(i)))
                begin
                    if (cellHitCfg)
                    begin
                        cellCfg[i] <= mergeBytes(cellCfg[i], writedata, byteenable);
                    end
                    if (cellHitSel)
                    begin
                        cellSel[i] <= 16'(mergeBytes({16'h0000, cellSel[i]}, writedata,
                                                     byteenable));
                    end
                end
            end
        end
    endgenerate

endmodule // logic_cluster

// [inc/cluster_pkg.sv]
/*
 * constants and carrier types of the logic cluster.
 * assumes one core clock and a byte-addressed register port.
 */
package cluster_pkg;

    // =====
    // sizes
    localparam int CELL_COUNT = 10;
    localparam int ROW_CLOCKS = 8;
    localparam int LOCAL_LINES = 16;
    localparam int CTRL_COUNT = 10;
    localparam int SEL_W = 4;
    localparam int ADDR_W = 8;
    localparam int CLOCK_PERIOD_NS = 50;

    // =====
    // register offsets (byte addresses)
    localparam logic [7:0] OFF_SRC_A = 8'h00;
    localparam logic [7:0] OFF_SRC_B = 8'h04;
    localparam logic [7:0] OFF_USE = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_CHAIN = 8'h10;
    localparam logic [7:0] OFF_CELL_CFG = 8'h40;
    localparam logic [7:0] OFF_CELL_SEL = 8'h80;

    // =====
    // values after reset
    localparam logic [31:0] RST_SRC_A = 32'h0000_0000;
    localparam logic [7:0] RST_SRC_B = 8'h00;
    localparam logic [9:0] RST_USE = 10'h000;
    localparam logic [31:0] RST_CELL_CFG = 32'h0000_0000;
    localparam logic [15:0] RST_CELL_SEL = 16'h0000;

    // =====
    // control indices in use mask and source fields
    localparam int CTL_CLK1 = 0;
    localparam int CTL_CLK2 = 1;
    localparam int CTL_ENA1 = 2;
    localparam int CTL_ENA2 = 3;
    localparam int CTL_ACLR1 = 4;
    localparam int CTL_ACLR2 = 5;
    localparam int CTL_SCLR = 6;
    localparam int CTL_APRE = 7;
    localparam int CTL_SLOAD = 8;
    localparam int CTL_ADDSUB = 9;

    // cell register input and clear selects
    localparam logic [1:0] DSEL_LUT = 2'h0;
    localparam logic [1:0] DSEL_REG_CHAIN = 2'h1;
    localparam logic [1:0] DSEL_DATA2 = 2'h2;
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_ONE = 2'h1;
    localparam logic [1:0] CLR_TWO = 2'h2;
    localparam logic [1:0] CLR_BOTH = 2'h3;

    // =====
    // carriers
    typedef struct packed {
        logic [7:0] spare;
        logic arith;
        logic lutChain;
        logic [1:0] dSel;
        logic presetUse;
        logic [1:0] clrSel;
        logic clkSel;
        logic [15:0] lutMask;
    } cell_cfg_t;

    typedef struct packed {
        logic addSub;
        logic sload;
        logic apre;
        logic sclr;
        logic aclr2;
        logic aclr1;
        logic ena2;
        logic ena1;
        logic clk2;
        logic clk1;
    } ctrl_t;

endpackage

// [test/fabric_model.sv]
/*
 routing fabric and row clocks around one logic cluster.
 assumes tasks are called from one bench thread.
*/
`timescale 1ns/10ps

module fabric_model
(
    input wire logic core_clk,
    output logic [7:0] rowClock,
    output logic [1:0] rowRoute,
    output logic [1:0] colRoute,
    output logic leftLink,
    output logic rightLink,
    output logic carryIn,
    output logic lutChainIn,
    output logic regChainIn
);
    // =====
    // drivers, changed after a rising edge
    initial
    begin
        {rowClock, rowRoute, colRoute, leftLink, rightLink} = 14'h0000;
        {carryIn, lutChainIn, regChainIn} = 3'h0;
    end

    task automatic setRow(input int i, input logic v);
        @(posedge core_clk);
        rowClock[i] <= v;
    endtask

    // row clocks rest low between pulses
    task automatic pulse(input int i);
        setRow(i, 1'b1);
        repeat (3) @(posedge core_clk);
        setRow(i, 1'b0);
        repeat (4) @(posedge core_clk);
    endtask

    task automatic setData(input logic [1:0] rr, input logic ci, input logic rc);
        @(posedge core_clk);
        rowRoute <= rr;
        carryIn <= ci;
        regChainIn <= rc;
    endtask

    // lines no test depends on still get live values
    task automatic jitter();
        @(posedge core_clk);
        {colRoute, leftLink, rightLink, lutChainIn} <= 5'($urandom);
    endtask
endmodule // fabric_model

// [test/logic_cluster_assertions.sv]
/*
 checker of the logic cluster: bus, gating, control sources.
 assumes binding to logic_cluster ports only.
*/
`timescale 1ns/10ps

module logic_cluster_assertions
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic [7:0] rowClock,
    input wire logic [1:0] rowRoute,
    input wire logic [1:0] colRoute,
    input wire logic leftLink,
    input wire logic rightLink,
    input wire logic [9:0] cellReg,
    input wire logic regChainOut,
    input wire logic [9:0] ctrlActive
);
    // =====
    // helper counters
    // controls that may move a register
    localparam logic [9:0] MOVERS = 10'h0bc;
    logic [3:0] sinceCtl;
    logic [3:0] quiet;
    logic [3:0] idle;

    always_ff @(posedge core_clk)
    begin
        if (rst || (ctrlActive & MOVERS) != 10'h000)
            sinceCtl <= 4'h0;
        else if (sinceCtl != 4'hf)
            sinceCtl <= sinceCtl + 4'h1;
    end

    // routing change or write restarts the count
    always_ff @(posedge core_clk)
    begin
        if (rst || write || $changed({rowClock, rowRoute, colRoute, leftLink, rightLink, cellReg}))
            quiet <= 4'h0;
        else if (quiet != 4'hf)
            quiet <= quiet + 4'h1;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst || ctrlActive != 10'h000)
            idle <= 4'h0;
        else if (idle != 4'hf)
            idle <= idle + 4'h1;
    end

    // =====
    // properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_taken; (read || write) && waitrequest; endsequence
    sequence s_answer; !waitrequest ##1 waitrequest; endsequence
    property p_ack_one; s_taken |=> s_answer; endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("answer not one cycle");
    property p_no_spurious; !waitrequest |-> (read || write) && $past(waitrequest); endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("answer without request");
    property p_rdata_hold; !(read || write) |=> $stable(readdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved idle");
    property p_chain_out; regChainOut == cellReg[9]; endproperty
    a_chain_out: assert property (p_chain_out)
        else $error("chain out mismatch");
    property p_gated; $changed(cellReg) |-> sinceCtl < 4'h6; endproperty
    a_gated: assert property (p_gated)
        else $error("register moved ungated");
    property p_idle_hold; idle >= 4'h4 |-> $stable(cellReg); endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("register moved while idle");
    property p_ctrl_src; quiet >= 4'h5 |-> $stable(ctrlActive); endproperty
    a_ctrl_src: assert property (p_ctrl_src)
        else $error("control moved with sources steady");
    property p_sclr;
        ctrlActive[6] && $past(ctrlActive[6]) && (ctrlActive & 10'h0b0) == 10'h000
            && $changed(cellReg) |-> cellReg == 10'h000;
    endproperty
    a_sclr: assert property (p_sclr)
        else $error("sync clear left a bit set");
endmodule // logic_cluster_assertions

bind logic_cluster logic_cluster_assertions chk_u (.core_clk(core_clk), .rst(rst),
    .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .rowClock(rowClock), .rowRoute(rowRoute), .colRoute(colRoute), .leftLink(leftLink),
    .rightLink(rightLink), .cellReg(cellReg), .regChainOut(regChainOut),
    .ctrlActive(ctrlActive));

// [test/test_logic_cluster.sv]
/*
 self-checking bench of the logic cluster.
 assumes fabric_model drives the routing side.
*/
`timescale 1ns/10ps

module test_logic_cluster;
    // =====
    // signals
    typedef struct {string name; logic [31:0] exp; logic [31:0] mask;} note_t;
    note_t notes[$];
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;
    int k;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [7:0] rowClock;
    logic [1:0] rowRoute;
    logic [1:0] colRoute;
    logic leftLink, rightLink, carryIn, lutChainIn, regChainIn;
    logic [9:0] cellReg;
    logic [9:0] ctrlActive;
    logic lutChainOut, regChainOut, carryOut, ci;
    logic [9:0] pat;
    logic [10:0] sum;
    logic [31:0] d;

    always #25 core_clk = ~core_clk;

    logic_cluster dut_u (.core_clk(core_clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .rowClock(rowClock), .rowRoute(rowRoute),
        .colRoute(colRoute), .leftLink(leftLink), .rightLink(rightLink), .carryIn(carryIn),
        .lutChainIn(lutChainIn), .regChainIn(regChainIn), .cellReg(cellReg),
        .lutChainOut(lutChainOut), .regChainOut(regChainOut), .carryOut(carryOut),
        .ctrlActive(ctrlActive));
    fabric_model fab_u (.core_clk(core_clk), .rowClock(rowClock), .rowRoute(rowRoute),
        .colRoute(colRoute), .leftLink(leftLink), .rightLink(rightLink), .carryIn(carryIn),
        .lutChainIn(lutChainIn), .regChainIn(regChainIn));

    // =====
    // bus tasks, monitor, report
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] v,
                       input logic [3:0] be);
        @(posedge core_clk);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= v;
        byteenable <= be;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus(1'b1, a, v, 4'hf);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                      input string s);
        notes.push_back('{s, e, m});
        bus(1'b0, a, 32'h0, 4'hf);
    endtask

    task automatic cfgAll(input logic [7:0] base, input logic [31:0] c);
        for (int i = 0; i < 10; i++)
            wr(base + 8'(4 * i), c);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // read data are set at the answering edge and held until the next request, so compare there
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles > 10000)
        begin
            n_mismatch++;
            final_report();
        end
        if (read === 1'b1 && waitrequest === 1'b0 && notes.size() > 0)
        begin
            n_checks++;
            if (((readdata ^ notes[0].exp) & notes[0].mask) !== 32'h0)
            begin
                n_mismatch++;
                $display("CHECK FAILED %s expected %h seen %h", notes[0].name,
                         notes[0].exp, readdata);
            end
            void'(notes.pop_front());
        end
    end

    // =====
    // tests
    initial
    begin
        void'($urandom(69));
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        fab_u.jitter();
        rd(cluster_pkg::OFF_SRC_A, 32'h0, 32'hffffffff, "src a reset");
        rd(cluster_pkg::OFF_USE, 32'h0, 32'h3ff, "use reset");
        rd(cluster_pkg::OFF_CELL_CFG, 32'h0, 32'hffffffff, "cell cfg reset");
        rd(cluster_pkg::OFF_STATUS, 32'h0, 32'h03ff03ff, "status reset");
        wr(8'h3c, $urandom);
        rd(8'h3c, 32'h0, 32'hffffffff, "unmapped");
        bus(1'b1, cluster_pkg::OFF_SRC_A, 32'hffffffff, 4'h5);
        rd(cluster_pkg::OFF_SRC_A, 32'h00ff00ff, 32'hffffffff, "byte lanes");
        d = $urandom;
        wr(cluster_pkg::OFF_SRC_B, d);
        rd(cluster_pkg::OFF_SRC_B, d, 32'hff, "src b");
        $display("test registers done");

        pat = 10'($urandom) | 10'h001;
        fab_u.setRow(1, 1'b1);
        wr(cluster_pkg::OFF_SRC_B, 32'h0);
        wr(cluster_pkg::OFF_SRC_A, 32'h00000100);
        wr(cluster_pkg::OFF_USE, 32'h005);
        cfgAll(cluster_pkg::OFF_CELL_CFG, 32'h00100000);
        for (k = 9; k >= 0; k--)
        begin
            fab_u.setData(2'h0, 1'b0, pat[k]);
            fab_u.pulse(0);
        end
        rd(cluster_pkg::OFF_STATUS, {16'h0004, 6'h0, pat}, 32'h03ff03ff, "shift");
        rd(cluster_pkg::OFF_CHAIN, {31'h0, pat[9]}, 32'h1, "chain out");
        fab_u.setRow(1, 1'b0);
        repeat (6) @(posedge core_clk);
        fab_u.pulse(0);
        rd(cluster_pkg::OFF_STATUS, {22'h0, pat}, 32'h3ff, "gated hold");
        $display("test shift chain done");

        fab_u.jitter();
        wr(cluster_pkg::OFF_SRC_A, 32'h00001100);
        wr(cluster_pkg::OFF_USE, 32'h00a);
        cfgAll(cluster_pkg::OFF_CELL_CFG, 32'h00110000);
        fab_u.setData(2'h0, 1'b0, 1'b1);
        fab_u.setRow(1, 1'b1);
        repeat (6) @(posedge core_clk);
        fab_u.setRow(0, 1'b1);
        repeat (8) @(posedge core_clk);
        rd(cluster_pkg::OFF_STATUS, {22'h0, pat}, 32'h3ff, "no rise tick");
        fab_u.setRow(0, 1'b0);
        repeat (8) @(posedge core_clk);
        rd(cluster_pkg::OFF_STATUS, {22'h0, pat[8:0], 1'b1}, 32'h3ff, "fall tick");
        $display("test falling edge done");

        wr(cluster_pkg::OFF_SRC_A, 32'h03000100);
        wr(cluster_pkg::OFF_USE, 32'h045);
        cfgAll(cluster_pkg::OFF_CELL_CFG, 32'h00100000);
        fab_u.setRow(3, 1'b1);
        repeat (6) @(posedge core_clk);
        fab_u.pulse(0);
        rd(cluster_pkg::OFF_STATUS, 32'h0, 32'h3ff, "sync clear");
        fab_u.setRow(3, 1'b0);
        $display("test sync clear done");

        wr(cluster_pkg::OFF_SRC_A, 32'h00000100);
        wr(cluster_pkg::OFF_SRC_B, 32'h20);
        wr(cluster_pkg::OFF_USE, 32'h205);
        cfgAll(cluster_pkg::OFF_CELL_SEL, 32'h00ef);
        cfgAll(cluster_pkg::OFF_CELL_CFG, 32'h00800000);
        for (k = 0; k < 8; k++)
        begin
            ci = 1'($urandom);
            fab_u.setData({k[0], k[1]}, ci, 1'b0);
            fab_u.setRow(2, k[2]);
            repeat (6) @(posedge core_clk);
            fab_u.pulse(0);
            sum = {1'b0, {10{k[0]}}} + {1'b0, {10{k[1] ^ k[2]}}} + 11'(k[2] | ci);
            rd(cluster_pkg::OFF_CHAIN, {29'h0, sum[10], 2'h0}, 32'h4, "carry");
            rd(cluster_pkg::OFF_STATUS, {22'h0, sum[9:0]}, 32'h3ff, "sum");
            n_checks++;
            if ({carryOut, lutChainOut} !== sum[10:9])
            begin
                n_mismatch++;
                $display("CHECK FAILED outs expected %h seen %h", sum[10:9],
                         {carryOut, lutChainOut});
            end
        end
        $display("test add subtract done");
        final_report();
    end
endmodule // test_logic_cluster
